// ===== inc/spio_pkg.sv
/*
 * Constants, pin bundle, state encoding and state record for the scanned
 * parallel I/O block. Assumes a 10 MHz system clock.
 */
package spio_pkg;

   // Buffer geometry
   localparam int          NUM_LOC      = 32;
   localparam int          NUM_SEL      = 16;

   // APB register byte offsets
   localparam logic [7:0]  CTRL_OFS     = 8'h00;
   localparam logic [7:0]  STAT_OFS     = 8'h04;

   // CTRL fields and reset values
   localparam int          CTRL_SEL_LSB = 0;
   localparam int          CTRL_INV_LSB = 2;
   localparam logic [1:0]  CTRL_SEL_RST = 2'h0;
   localparam logic [3:0]  CTRL_INV_RST = 4'h0;

   // Phase control code of the processor I/O phase
   localparam logic [1:0]  PHASE_IO     = 2'h1;

   // Timing
   localparam int          CLK_MHZ      = 10;
   localparam int          SLOT_BASE_US = 320;
   localparam int          SLOT_BASE_CYC = SLOT_BASE_US * CLK_MHZ;
   localparam int          OUT_VALID_US = 40;
   localparam int          OUT_VALID_CYC = OUT_VALID_US * CLK_MHZ;
   localparam int          PULSE_NUM    = 8;
   localparam int          HOLD_NUM     = 1;
   localparam int          FRAC_DEN     = 10;

   typedef enum logic [2:0] {
      ST_CLEAR   = 3'b000,
      ST_WAIT_IO = 3'b001,
      ST_IO      = 3'b010,
      ST_PEND    = 3'b011,
      ST_SCAN    = 3'b100
   } spio_state_t;

   typedef struct packed {
      logic [10:0] addr;
      logic        avh;
      logic [1:0]  phase;
      logic        stb;
      logic [3:0]  cpu_nibble_data;
      logic        prst_n;
      logic        start;
      logic [3:0]  split;
      logic        inv_in;
      logic        inv_out;
      logic [5:0]  id;
      logic [7:0]  db;
   } spio_pins_t;

   typedef struct packed {
      spio_pins_t           s1;
      spio_pins_t           s2;
      logic                 stb_q;
      spio_state_t          state;
      logic [31:0][3:0]     buffer;
      logic [3:0]           idx;
      logic [15:0]          cnt;
      logic [1:0]           slot_sel;
      logic [3:0]           en_inv;
      logic [15:0]          en_n;
      logic [7:0]           db_o;
      logic                 db_oe;
      logic [3:0]           dio_o;
      logic                 dio_oe;
      logic                 ready_n;
      logic                 cpu_dir;
      logic                 exch_done;
      logic                 prep_done;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
   } spio_regs_t;

endpackage : spio_pkg

// ===== logic/spio_top.sv
/*
 * Scanned parallel I/O block: 32-nibble buffer shared between a processor
 * nibble port and sixteen strobed byte devices, plus an APB control slave.
 * Assumes all processor and device pins are asynchronous to CLK, and that
 * the pad ring resolves the two-way pins from the enables.
 */
`timescale 1ns/10ps

module spio_top #(
   parameter int SLOT_BASE = spio_pkg::SLOT_BASE_CYC
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Processor side
   input  wire logic [10:0] ADDR,
   input  wire logic        ADDRESS_VALID_HANDSHAKE,
   input  wire logic [1:0]  PHASE_CONTROL,
   input  wire logic        STORE_STROBE,
   input  wire logic        PROCESSOR_RESET_N,
   input  wire logic [5:0]  MODULE_ID,
   input  wire logic [3:0]  CPU_NIBBLE_DATA_I,
   output logic      [3:0]  CPU_NIBBLE_DATA_O,
   output logic             CPU_NIBBLE_DATA_OE,
   output logic             CPU_DIR,
   output logic             EXCHANGE_DONE,
   output logic             PREPARATION_DONE,
   // Device side
   input  wire logic        START,
   input  wire logic [3:0]  IO_SPLIT_CODE,
   input  wire logic        INPUT_POLARITY_INVERT,
   input  wire logic        OUTPUT_POLARITY_INVERT,
   input  wire logic [7:0]  DEVICE_DATA_BUS_I,
   output logic      [7:0]  DEVICE_DATA_BUS_O,
   output logic             DEVICE_DATA_BUS_OE,
   output logic      [15:0] SELECT_N,
   output logic             READY_N
);

   spio_pkg::spio_regs_t r;
   spio_pkg::spio_regs_t n;
   spio_pkg::spio_pins_t pins;
   logic [15:0]          slot_len;
   logic [15:0]          pulse_len;
   logic [15:0]          hold_len;
   logic [15:0]          inv16;
   logic [4:0]           loc;
   logic                 hit;
   logic                 in_loc;
   logic                 stb_rise;
   logic                 scan_out;
   logic [7:0]           din;

   // Index below split code means an output device
   function automatic logic grp_out(input logic [3:0] i, input logic [3:0] split);
      grp_out = (i < split);
   endfunction : grp_out

   assign pins = '{addr: ADDR, avh: ADDRESS_VALID_HANDSHAKE, phase: PHASE_CONTROL,
                   stb: STORE_STROBE, cpu_nibble_data: CPU_NIBBLE_DATA_I,
                   prst_n: PROCESSOR_RESET_N, start: START, split: IO_SPLIT_CODE,
                   inv_in: INPUT_POLARITY_INVERT, inv_out: OUTPUT_POLARITY_INVERT,
                   id: MODULE_ID, db: DEVICE_DATA_BUS_I};

   // two-bit code picks one of four slot lengths, base shifted left by 0 to 3
   assign slot_len  = 16'(SLOT_BASE) << r.slot_sel;
   assign pulse_len = 16'((32'(slot_len) * spio_pkg::PULSE_NUM) / spio_pkg::FRAC_DEN);
   assign hold_len  = 16'((32'(slot_len) * spio_pkg::HOLD_NUM) / spio_pkg::FRAC_DEN);
   assign inv16     = {r.en_inv[3], r.en_inv[2], 12'h000, r.en_inv[1], r.en_inv[0]};

   assign loc       = r.s2.addr[4:0];
   assign in_loc    = !grp_out(loc[4:1], r.s2.split);
   // identity match, handshake qualifies, blocked during scan
   assign hit       = r.s2.avh && (r.s2.addr[10:5] == r.s2.id)
                      && (r.s2.phase == spio_pkg::PHASE_IO)
                      && (r.state == spio_pkg::ST_WAIT_IO || r.state == spio_pkg::ST_IO);
   assign stb_rise  = r.s2.stb && !r.stb_q;
   assign scan_out  = grp_out(r.idx, r.s2.split);
   assign din       = r.s2.inv_in ? ~r.s2.db : r.s2.db;

   always_comb
   begin
      n       = r;
      n.s1    = pins;
      n.s2    = r.s1;
      n.stb_q = r.s2.stb;

      // APB: decode in setup, answer in first access cycle
      n.pready  = PSEL && !PENABLE;
      n.pslverr = 1'b0;
      if (PSEL && !PENABLE)
      begin
         case (PADDR)
            spio_pkg::CTRL_OFS: n.prdata = {26'h0000000, r.en_inv, r.slot_sel};
            spio_pkg::STAT_OFS: n.prdata = {23'h000000, r.state, r.idx,
                                            r.ready_n, r.state == spio_pkg::ST_SCAN};
            default:
            begin
               n.prdata  = 32'h00000000;
               n.pslverr = 1'b1;
            end
         endcase
      end
      if (PSEL && PENABLE && r.pready && PWRITE && PADDR == spio_pkg::CTRL_OFS)
      begin
         n.slot_sel = PWDATA[spio_pkg::CTRL_SEL_LSB +: 2];
         n.en_inv   = PWDATA[spio_pkg::CTRL_INV_LSB +: 4];
      end

      // Processor port and device bus enable defaults
      n.prep_done = 1'b0;
      n.dio_oe    = 1'b0;
      n.cpu_dir   = 1'b1;
      n.dio_o     = r.buffer[loc];
      n.db_oe     = 1'b0;

      case (r.state)
         spio_pkg::ST_CLEAR:
         begin
            // buffer cleared before first I/O phase
            n.buffer = '0;
            if (r.s2.prst_n)
               n.state = spio_pkg::ST_WAIT_IO;
         end
         spio_pkg::ST_WAIT_IO, spio_pkg::ST_IO:
         begin
            if (hit)
            begin
               n.prep_done = 1'b1;
               n.cpu_dir   = !in_loc;
               n.dio_oe    = in_loc;
               n.state     = spio_pkg::ST_IO;
               if (stb_rise && !in_loc)
                  n.buffer[loc] = r.s2.cpu_nibble_data;
            end
            // scan follows the end of the I/O phase
            if (r.state == spio_pkg::ST_IO && r.s2.phase != spio_pkg::PHASE_IO)
               n.state = r.s2.start ? spio_pkg::ST_SCAN : spio_pkg::ST_PEND;
            n.idx = 4'h0;
            n.cnt = 16'h0000;
         end
         spio_pkg::ST_PEND:
         begin
            if (r.s2.start)
               n.state = spio_pkg::ST_SCAN;
         end
         spio_pkg::ST_SCAN:
         begin
            // drive output data through pulse plus hold window
            n.db_oe = scan_out && (r.cnt < pulse_len + hold_len);
            // byte from locations 2i and 2i+1
            n.db_o  = {r.buffer[{r.idx, 1'b1}], r.buffer[{r.idx, 1'b0}]}
                      ^ (r.s2.inv_out ? 8'h00 : 8'hFF);
            // capture input byte at the end of the pulse
            if (!scan_out && r.cnt == pulse_len - 16'h0001)
            begin
               n.buffer[{r.idx, 1'b0}] = din[3:0];
               n.buffer[{r.idx, 1'b1}] = din[7:4];
            end
            // slot counter walks select 0 to 15
            if (r.cnt >= slot_len - 16'h0001)
            begin
               n.cnt = 16'h0000;
               n.idx = r.idx + 4'h1;
               if (r.idx == 4'hF)
                  n.state = spio_pkg::ST_WAIT_IO;
            end
            else
               n.cnt = r.cnt + 16'h0001;
         end
         default:
            n.state = spio_pkg::ST_CLEAR;
      endcase

      // exchange done; set by a new exchange, held until hit drops
      if (hit && ((stb_rise && !in_loc) || (in_loc && r.dio_oe)))
         n.exch_done = 1'b1;
      else if (!hit)
         n.exch_done = 1'b0;

      // one select low for 0.8 slot, then a 0.2 slot gap
      n.en_n = 16'hFFFF;
      if (r.state == spio_pkg::ST_SCAN && r.cnt < pulse_len)
         n.en_n[r.idx] = 1'b0;
      n.en_n = n.en_n ^ inv16;

      // processor reset restarts from the clear
      if (!r.s2.prst_n)
         n.state = spio_pkg::ST_CLEAR;

      // ready low while the buffer is open to the processor
      n.ready_n = (n.state == spio_pkg::ST_SCAN || n.state == spio_pkg::ST_CLEAR);

      if (!RST_N)
      begin
         n          = '0;
         n.state    = spio_pkg::ST_CLEAR;
         n.slot_sel = spio_pkg::CTRL_SEL_RST;
         n.en_inv   = spio_pkg::CTRL_INV_RST;
         n.en_n     = 16'hFFFF;
         n.ready_n  = 1'b1;
         n.cpu_dir  = 1'b1;
      end
   end

   always_ff @(posedge CLK)
   begin
      r <= n;
   end

   assign PRDATA             = r.prdata;
   assign PREADY             = r.pready;
   assign PSLVERR            = r.pslverr;
   assign CPU_NIBBLE_DATA_O  = r.dio_o;
   assign CPU_NIBBLE_DATA_OE = r.dio_oe;
   assign CPU_DIR            = r.cpu_dir;
   assign EXCHANGE_DONE      = r.exch_done;
   assign PREPARATION_DONE   = r.prep_done;
   assign DEVICE_DATA_BUS_O  = r.db_o;
   assign DEVICE_DATA_BUS_OE = r.db_oe;
   assign SELECT_N           = r.en_n;
   assign READY_N            = r.ready_n;

   // Helper: length of each select pulse, true polarity
   // Mask lags one cycle, as the select register does, so a CTRL write
   // does not look like a one-cycle pulse
   logic        sel_any;
   logic [15:0] pcnt;
   logic [15:0] inv_q;
   assign sel_any = !(&(r.en_n ^ inv_q));

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         pcnt  <= 16'h0000;
         inv_q <= 16'h0000;
      end
      else
      begin
         pcnt  <= sel_any ? pcnt + 16'h0001 : 16'h0000;
         inv_q <= inv16;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   scan_blocks_cpu_a : assert property (
      (r.state == spio_pkg::ST_SCAN) ##1 (r.state == spio_pkg::ST_SCAN)
      |-> !PREPARATION_DONE && !CPU_NIBBLE_DATA_OE)
      else $error("processor served during scan");
   ready_after_scan_a : assert property (
      (r.state == spio_pkg::ST_SCAN) ##1 (r.state == spio_pkg::ST_WAIT_IO) |-> !READY_N)
      else $error("ready not low after scan");
   one_select_a : assert property (
      $stable(r.en_inv) |-> $onehot0(~(SELECT_N ^ inv16)))
      else $error("more than one select active");
   out_drive_a : assert property (
      DEVICE_DATA_BUS_OE |-> $past(grp_out(r.idx, r.s2.split)))
      else $error("bus driven for an input device");
   clear_buffer_a : assert property (
      (r.state == spio_pkg::ST_CLEAR) |=> (r.buffer == '0))
      else $error("buffer not cleared");
   id_match_a : assert property (
      PREPARATION_DONE |-> $past(r.s2.avh && r.s2.addr[10:5] == r.s2.id))
      else $error("answered foreign address");
   dir_low_input_a : assert property (
      PREPARATION_DONE |-> (CPU_DIR == $past(grp_out(r.s2.addr[4:1], r.s2.split))))
      else $error("direction output wrong");
   pulse_len_a : assert property (
      ($fell(sel_any) && $stable(r.slot_sel)) |-> (pcnt == pulse_len))
      else $error("select pulse length wrong");
   start_scan_a : assert property (
      (r.state == spio_pkg::ST_IO && r.s2.phase != spio_pkg::PHASE_IO && r.s2.start
       && r.s2.prst_n) |=> (r.state == spio_pkg::ST_SCAN))
      else $error("scan did not start");

   scan_done_c  : cover property ((r.state == spio_pkg::ST_SCAN) ##1 (r.state == spio_pkg::ST_WAIT_IO));
   cpu_write_c  : cover property (hit && stb_rise && !in_loc);
   cpu_read_c   : cover property (PREPARATION_DONE && CPU_NIBBLE_DATA_OE);
   pend_start_c : cover property ((r.state == spio_pkg::ST_PEND) ##1 (r.state == spio_pkg::ST_SCAN));

endmodule : spio_top

// ===== tb/spio_dev_model.sv
/*
 * Behavioural byte devices hanging on the strobed device bus.
 * Assumes active-low selects, at most one active at a time, and a bus
 * that the block drives only while its output enable is high.
 */
`timescale 1ns/10ps
module spio_dev_model (
   // Clock
   input  wire logic        clk,
   // Selects and device bus
   input  wire logic [15:0] sel_n,
   input  wire logic [7:0]  bus_o,
   input  wire logic        bus_oe,
   output logic      [7:0]  bus_i
);
   logic [7:0]  in_byte [16];
   logic [7:0]  out_byte [16];
   int          plen [16];
   int          order [$];
   logic [15:0] sel_q = 16'hFFFF;
   int          cnt = 0;
   logic        any;
   logic [7:0]  drv;

   initial bus_i = 8'h00;

   always @(posedge clk)
   begin
      any = 1'b0;
      // Released bus keeps toggling so a stale byte is never mistaken
      drv = ~bus_i;
      for (int k = 0; k < 16; k++)
      begin
         if (!sel_n[k] && sel_q[k])
         begin
            order.push_back(k);
         end
         // Output device latches at the end of its pulse
         if (sel_n[k] && !sel_q[k])
         begin
            plen[k] = cnt;
            out_byte[k] = bus_oe ? bus_o : 8'hXX;
         end
         if (!sel_n[k])
         begin
            any = 1'b1;
            drv = in_byte[k];
         end
      end
      cnt = any ? ((sel_q == 16'hFFFF) ? 1 : cnt + 1) : 0;
      sel_q <= sel_n;
      bus_i <= drv;
   end
endmodule : spio_dev_model

// ===== tb/tb_top.sv
/*
 * Self-checking bench for the scanned parallel I/O block.
 * Assumes a 10 MHz clock, a shortened slot parameter and the device model.
 */
`timescale 1ns/10ps
module tb_top;
   localparam int         SB  = 20;
   // Arbitrary strap value
   localparam logic [5:0] MID = 6'h2A;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, avh = 0, stb = 0, prst_n = 0, start = 1;
   logic [10:0] addr = 11'h000;
   logic [1:0]  phase = 2'h0;
   logic [3:0]  cdi = 4'h0, cdo, split_code = 4'h0;
   logic        cdoe, cdir, exch, prep, inv_in = 1, inv_out = 1, dboe, ready_n;
   logic [7:0]  dbi, dbo;
   logic [15:0] sel_n;
   int          fails = 0, checks = 0, cyc = 0, split, sel;
   logic [3:0]  nib [32];
   logic [31:0] rd;
   logic        er, ii, io;

   always #50 clk = ~clk;

   spio_top #(.SLOT_BASE(SB)) dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ADDR(addr),
      .ADDRESS_VALID_HANDSHAKE(avh), .PHASE_CONTROL(phase), .STORE_STROBE(stb),
      .PROCESSOR_RESET_N(prst_n), .MODULE_ID(MID), .CPU_NIBBLE_DATA_I(cdi),
      .CPU_NIBBLE_DATA_O(cdo), .CPU_NIBBLE_DATA_OE(cdoe), .CPU_DIR(cdir),
      .EXCHANGE_DONE(exch), .PREPARATION_DONE(prep), .START(start),
      .IO_SPLIT_CODE(split_code), .INPUT_POLARITY_INVERT(inv_in),
      .OUTPUT_POLARITY_INVERT(inv_out), .DEVICE_DATA_BUS_I(dbi),
      .DEVICE_DATA_BUS_O(dbo), .DEVICE_DATA_BUS_OE(dboe), .SELECT_N(sel_n),
      .READY_N(ready_n));

   spio_dev_model dev (.clk(clk), .sel_n(sel_n), .bus_o(dbo), .bus_oe(dboe),
      .bus_i(dbi));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic summarize;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         summarize;
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb

   task automatic cpu(input int loc, input logic w, input logic [3:0] d,
                      input logic dir);
      @(posedge clk);
      addr <= {MID, loc[4:0]}; avh <= 1; phase <= 2'h1; cdi <= d;
      repeat (6) @(posedge clk);
      check(prep, 1);
      check(cdir, dir);
      if (w)
      begin
         stb <= 1;
         repeat (6) @(posedge clk);
         check(exch, 1);
         stb <= 0;
      end
      else
      begin
         check(cdoe, 1);
         rd = cdo;
         repeat (2) @(posedge clk);
         check(exch, 1);
      end
      avh <= 0;
      repeat (5) @(posedge clk);
   endtask : cpu

   task automatic wait_ready(input logic v);
      int n;
      n = 0;
      while (ready_n !== v && n < 5000)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_ready

   function automatic logic [7:0] out_exp(input int k);
      return {nib[2*k+1], nib[2*k]} ^ (io ? 8'h00 : 8'hFF);
   endfunction : out_exp

   function automatic logic [7:0] in_exp(input int k);
      return dev.in_byte[k] ^ (ii ? 8'hFF : 8'h00);
   endfunction : in_exp

   initial
   begin
      void'($urandom(31627));
      repeat (12) @(posedge clk);
      rst_n <= 1;
      repeat (4) @(posedge clk);
      prst_n <= 1;
      wait_ready(0);
      check(ready_n, 0);
      apb(1, spio_pkg::CTRL_OFS, 32'h3C);
      apb(0, spio_pkg::CTRL_OFS, 32'h0);
      check(rd, 32'h3C);
      check(sel_n, 16'h3FFC);
      apb(0, 8'h08, 32'h0);
      check(er, 1);
      check(rd, 32'h0);
      apb(0, spio_pkg::STAT_OFS, 32'h0);
      check(rd, 32'h00000040);
      $display("test registers done");
      cpu(5, 0, 4'h0, 0);
      check(rd, 32'h0);
      addr <= {~MID, 5'h03}; avh <= 1; phase <= 2'h1;
      repeat (8) @(posedge clk);
      check(prep, 0);
      addr <= {MID, 5'h03}; avh <= 0;
      repeat (8) @(posedge clk);
      check(prep, 0);
      $display("test decode done");
      for (int r = 0; r < 4; r++)
      begin
         // one slot setting per scan, each code used once
         sel = 3 - r;
         split = $urandom_range(15, 1);
         ii = r[0];
         io = r[1];
         apb(1, spio_pkg::CTRL_OFS, sel);
         split_code <= split[3:0]; inv_in <= ii; inv_out <= io;
         for (int k = 0; k < 16; k++)
            dev.in_byte[k] = 8'($urandom);
         for (int i = 0; i < 2 * split; i++)
         begin
            nib[i] = 4'($urandom);
            cpu(i, 1, nib[i], 1);
         end
         dev.order.delete();
         if (r == 1)
         begin
            start <= 0;
            phase <= 2'h0;
            repeat (60) @(posedge clk);
            check(ready_n, 0);
            start <= 1;
         end
         phase <= 2'h0;
         wait_ready(1);
         check(ready_n, 1);
         addr <= {MID, 5'h1F}; avh <= 1; phase <= 2'h1;
         repeat (8) @(posedge clk);
         check(prep, 0);
         avh <= 0; phase <= 2'h0;
         wait_ready(0);
         check(ready_n, 0);
         check(dev.order.size(), 16);
         for (int k = 0; k < 16; k++)
         begin
            check(dev.order[k], k);
            check(dev.plen[k], (SB << sel) * 8 / 10);
            if (k < split)
               check(dev.out_byte[k], out_exp(k));
            else
            begin
               cpu(2 * k, 0, 4'h0, 0);
               check(rd, in_exp(k) & 8'h0F);
               cpu(2 * k + 1, 0, 4'h0, 0);
               check(rd, in_exp(k) >> 4);
            end
         end
         $display("test scan %0d done", r);
      end
      summarize;
   end
endmodule : tb_top
